/* File: rtl/emb_pkg.sv */
package emb_pkg;

  // Address split over the three ports
  localparam int ADDR_W = 22;
  localparam int NARROW_ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int EXT_ADDR_W = 6;
  localparam int FIFO_DEPTH = 16;

  // Reset vector locations
  localparam logic [ADDR_W-1:0] VEC_HI_ADDR = 22'h000000;
  localparam logic [ADDR_W-1:0] VEC_LO_ADDR = 22'h000001;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int DS_LOW_NS = 60;
  localparam int DS_LOW_CYC = (DS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Values after reset
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_VECTOR = 16'h0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic internal;
    logic [DATA_W-1:0] wdata;
  } emb_req_t;

  typedef enum {
    ST_IDLE,
    ST_AS_LOW,
    ST_AS_HIGH,
    ST_DS_LOW,
    ST_DS_END
  } emb_state_t;

endpackage : emb_pkg

/* File: rtl/emb_bus.sv */
`timescale 1ns/1ps

module emb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count <= '0;
      o_ready <= 1'b1;
    end else begin
      count <= next_count;
      o_ready <= (next_count != FULL);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

endmodule : emb_fifo

module emb_bus (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Request stream from the core
  input wire logic i_req_valid,
  input wire emb_pkg::emb_req_t i_req,
  output logic o_req_ready,
  // Read answers
  output logic o_rd_valid,
  output logic [emb_pkg::DATA_W-1:0] o_rd_data,
  // Reset vector
  output logic o_boot_done,
  output logic [15:0] o_vector,
  // Pin straps and controls
  input wire logic i_wide_bus,
  input wire logic i_bus_release,
  // Strobes and direction
  output logic o_addr_strobe_n,
  output logic o_data_strobe_n,
  output logic o_rw,
  output logic o_ctrl_oe,
  // Multiplexed address and data port
  input wire logic [emb_pkg::DATA_W-1:0] i_muxed_data_port,
  output logic [emb_pkg::DATA_W-1:0] o_muxed_data_port,
  output logic o_muxed_data_oe,
  // Upper address ports
  output logic [7:0] o_upper_address_port,
  output logic [emb_pkg::EXT_ADDR_W-1:0] o_extended_address_port
);
  localparam logic [1:0] DS_LAST = 2'(emb_pkg::DS_LOW_CYC - 1);

  emb_pkg::emb_state_t state;
  emb_pkg::emb_req_t cur;
  emb_pkg::emb_req_t fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic [1:0] ds_cnt;
  logic boot_idx;
  logic wide;
  logic strap_seen;
  logic wide_s1;
  logic wide_s2;
  logic rel_s1;
  logic rel_s2;
  logic [emb_pkg::DATA_W-1:0] din_s1;
  logic [emb_pkg::DATA_W-1:0] din_s2;

  function automatic logic [emb_pkg::ADDR_W-1:0] mask_addr(input logic [emb_pkg::ADDR_W-1:0] a, input logic w);
    mask_addr = w ? a : {11'h000, a[emb_pkg::NARROW_ADDR_W-1:0]};
  endfunction : mask_addr

  emb_fifo #(
    .WIDTH($bits(emb_pkg::emb_req_t)),
    .DEPTH(emb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_valid(i_req_valid),
    .i_data(i_req),
    .o_ready(o_req_ready),
    .o_valid(fifo_valid),
    .o_data(fifo_data),
    .i_ready(fifo_pop)
  );

  // Boot fetches first; the queue drains only once the vector is in
  assign fifo_pop = (state == emb_pkg::ST_IDLE) && o_boot_done && fifo_valid;

  // Strap flops run through reset, so the strap has settled when reset lifts
  always_ff @(posedge i_clk) begin
    wide_s1 <= i_wide_bus;
    wide_s2 <= wide_s1;
  end

  // Pin synchronisers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rel_s1 <= 1'b0;
      rel_s2 <= 1'b0;
      din_s1 <= emb_pkg::RST_BYTE;
      din_s2 <= emb_pkg::RST_BYTE;
    end else begin
      rel_s1 <= i_bus_release;
      rel_s2 <= rel_s1;
      din_s1 <= i_muxed_data_port;
      din_s2 <= din_s1;
    end
  end

  // Strap caught once after release, not under reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wide <= 1'b0;
      strap_seen <= 1'b0;
    end else if (!strap_seen) begin
      wide <= wide_s2;
      strap_seen <= 1'b1;
    end
  end

  // Floating the controls lets another master own the bus
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ctrl_oe <= 1'b1;
    end else begin
      o_ctrl_oe <= !rel_s2;
    end
  end

  // Cycle sequencer
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= emb_pkg::ST_IDLE;
      cur <= '0;
      ds_cnt <= 2'h0;
      o_addr_strobe_n <= 1'b1;
      o_data_strobe_n <= 1'b1;
      o_rw <= 1'b1;
      o_muxed_data_port <= emb_pkg::RST_BYTE;
      o_muxed_data_oe <= 1'b0;
      o_upper_address_port <= 8'h00;
      o_extended_address_port <= 6'h00;
    end else begin
      case (state)
        emb_pkg::ST_IDLE: begin
          if (strap_seen && (!o_boot_done || fifo_valid)) begin
            cur <= o_boot_done ? fifo_data : emb_pkg::emb_req_t'{
              addr: boot_idx ? emb_pkg::VEC_LO_ADDR : emb_pkg::VEC_HI_ADDR,
              write: 1'b0, internal: 1'b0, wdata: emb_pkg::RST_BYTE};
            {o_extended_address_port, o_upper_address_port, o_muxed_data_port} <=
              mask_addr(o_boot_done ? fifo_data.addr : {21'h000000, boot_idx}, wide);
            o_muxed_data_oe <= 1'b1;
            o_rw <= !(o_boot_done && fifo_data.write && !fifo_data.internal);
            o_addr_strobe_n <= 1'b0;
            state <= emb_pkg::ST_AS_LOW;
          end
        end
        emb_pkg::ST_AS_LOW: begin
          o_addr_strobe_n <= 1'b1;
          state <= emb_pkg::ST_AS_HIGH;
        end
        emb_pkg::ST_AS_HIGH: begin
          // Data and strobe change on one edge, address already latched
          o_muxed_data_port <= cur.wdata;
          o_muxed_data_oe <= cur.write && !cur.internal;
          o_data_strobe_n <= cur.internal;
          ds_cnt <= 2'h0;
          state <= emb_pkg::ST_DS_LOW;
        end
        emb_pkg::ST_DS_LOW: begin
          ds_cnt <= ds_cnt + 2'h1;
          if (ds_cnt == DS_LAST) begin
            o_data_strobe_n <= 1'b1;
            state <= emb_pkg::ST_DS_END;
          end
        end
        emb_pkg::ST_DS_END: begin
          o_muxed_data_oe <= 1'b0;
          o_rw <= 1'b1;
          state <= emb_pkg::ST_IDLE;
        end
        default: begin
          state <= emb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Answers and vector; read byte is the port one clock before the strobe rises,
  // as the two-flop synchroniser costs the remaining clocks
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= emb_pkg::RST_BYTE;
      o_boot_done <= 1'b0;
      o_vector <= emb_pkg::RST_VECTOR;
      boot_idx <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      if (state == emb_pkg::ST_DS_END && !cur.write && !cur.internal) begin
        if (!o_boot_done) begin
          if (boot_idx) begin
            o_vector[7:0] <= din_s2;
            o_boot_done <= 1'b1;
          end else begin
            o_vector[15:8] <= din_s2;
          end
          boot_idx <= 1'b1;
        end else begin
          o_rd_valid <= 1'b1;
          o_rd_data <= din_s2;
        end
      end
    end
  end

endmodule : emb_bus

/* File: dv/emb_bus_assertions.sv */
`timescale 1ns/1ps
module emb_bus_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Watched pins
  input wire logic i_bus_release,
  input wire logic o_addr_strobe_n,
  input wire logic o_data_strobe_n,
  input wire logic o_rw,
  input wire logic o_ctrl_oe,
  input wire logic [7:0] o_muxed_data_port,
  input wire logic o_muxed_data_oe,
  input wire logic [7:0] o_upper_address_port,
  input wire logic [5:0] o_extended_address_port,
  input wire logic o_rd_valid,
  input wire logic o_boot_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  as_pulse_a: assert property ($fell(o_addr_strobe_n) |=> $rose(o_addr_strobe_n))
    else $error("address strobe low not one clock");
  as_once_a: assert property ($rose(o_addr_strobe_n) |-> o_addr_strobe_n [*5])
    else $error("address strobe pulsed twice");
  addr_hold_a: assert property (
    $rose(o_addr_strobe_n) |-> $stable({o_extended_address_port, o_upper_address_port, o_muxed_data_port, o_rw}))
    else $error("address moved at strobe rise");
  wdata_hold_a: assert property (
    $fell(o_data_strobe_n) && !o_rw |-> o_muxed_data_oe ##1 $stable(o_muxed_data_port) [*2])
    else $error("write data not held under data strobe");
  int_quiet_a: assert property (
    $rose(o_addr_strobe_n) ##1 (o_data_strobe_n && !o_muxed_data_oe) |-> o_data_strobe_n [*4])
    else $error("data strobe fell in internal cycle");
  dir_match_a: assert property (!o_data_strobe_n |-> o_rw != o_muxed_data_oe)
    else $error("direction disagrees with port drive");
  rw_start_a: assert property ($fell(o_rw) |-> $fell(o_addr_strobe_n))
    else $error("direction low outside cycle start");
  ds_frame_a: assert property (
    $fell(o_data_strobe_n) |-> $past(o_addr_strobe_n, 2) == 1'b0 ##1 !o_data_strobe_n [*2] ##1 o_data_strobe_n)
    else $error("data strobe framing wrong");
  float_a: assert property ($rose(i_bus_release) |-> ##[1:4] !o_ctrl_oe)
    else $error("control lines not floated");
  boot_first_a: assert property (o_rd_valid |-> o_boot_done)
    else $error("read answered before boot");
  reset_idle_a: assert property (
    disable iff (1'b0) !i_nrst |-> o_addr_strobe_n && o_data_strobe_n)
    else $error("strobe active in reset");
  cover property ($fell(o_data_strobe_n) && !o_rw);
  cover property (o_rd_valid);
  cover property ($fell(o_ctrl_oe));
endmodule : emb_bus_chk

bind emb_bus emb_bus_chk i_chk (.*);

/* File: dv/emb_mem_model.sv */
`timescale 1ns/1ps
module emb_mem_model (
  // Clock and pace
  input wire logic i_clk,
  input wire logic i_slow,
  // Bus pins
  input wire logic i_addr_strobe_n,
  input wire logic i_data_strobe_n,
  input wire logic i_rw,
  input wire logic [7:0] i_port,
  input wire logic [13:0] i_upper,
  output logic [7:0] o_drv
);
  logic [7:0] mem [int];
  logic [21:0] addr;
  logic [7:0] last;
  int cnt = 0;
  function automatic logic [7:0] read_byte(int a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : read_byte
  always @(posedge i_addr_strobe_n) addr = {i_upper, i_port};
  always @(posedge i_data_strobe_n) if (!i_rw) mem[addr] = i_port;
  always @(posedge i_clk) begin
    last <= i_port;
    cnt <= i_data_strobe_n ? 0 : cnt + 1;
  end
  // Slow pace answers a clock late; undriven port shows the inverse of its last level
  assign o_drv = (!i_data_strobe_n && i_rw && (!i_slow || cnt > 0)) ? read_byte(addr) : ~last;
endmodule : emb_mem_model

/* File: dv/emb_bus_tb.sv */
`timescale 1ns/1ps
module emb_bus_tb;
  logic i_clk = 0, i_nrst = 1, i_req_valid = 0, i_wide_bus = 0, i_bus_release = 0, slow = 0;
  emb_pkg::emb_req_t i_req = '0;
  logic o_req_ready, o_rd_valid, o_boot_done, o_addr_strobe_n, o_data_strobe_n, o_rw;
  logic o_ctrl_oe, o_muxed_data_oe;
  logic [7:0] o_rd_data, o_muxed_data_port, o_upper_address_port, drv;
  logic [15:0] o_vector;
  logic [5:0] o_extended_address_port;
  wire [7:0] i_muxed_data_port = o_muxed_data_oe ? o_muxed_data_port : drv;
  logic [7:0] m [int];
  logic [7:0] q [$];
  int n_fail = 0, comparisons = 0, k;
  bit wide, seen_full;
  always #10 i_clk = ~i_clk;
  emb_bus i_dut (.*);
  emb_mem_model i_mem (.i_clk(i_clk), .i_slow(slow), .i_addr_strobe_n(o_addr_strobe_n),
    .i_data_strobe_n(o_data_strobe_n), .i_rw(o_rw), .i_port(i_muxed_data_port),
    .i_upper({o_extended_address_port, o_upper_address_port}), .o_drv(drv));
  function automatic logic [7:0] rd(int a);
    return m.exists(a) ? m[a] : a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : rd
  task automatic check(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic push(input logic wr, in, input int a);
    logic [7:0] d;
    d = $urandom;
    a = a & (wide ? 32'h3fffff : 32'h7ff);
    i_req_valid <= 1;
    i_req <= {a[21:0], wr, in, d};
    @(posedge i_clk);
    for (k = 0; k < 99 && o_req_ready !== 1'b1; k++) begin
      seen_full = 1;
      @(posedge i_clk);
    end
    if (!in && wr) m[a] = d;
    if (!in && !wr) q.push_back(rd(a));
  endtask : push
  always @(posedge i_clk) if (o_rd_valid === 1'b1) check(o_rd_data, q.pop_front());
  // Narrow strap leaves the extended lines and upper port bits 7:3 at zero
  always @(posedge i_clk) if (i_nrst && !wide && o_addr_strobe_n === 1'b0)
    check({o_extended_address_port, o_upper_address_port[7:3]}, 0);
  initial begin
    void'($urandom(67));
    for (int r = 0; r < 2; r++) begin
      wide = r;
      i_wide_bus <= r;
      i_nrst <= 0;
      repeat (3) @(posedge i_clk);
      i_nrst <= 1;
      for (k = 0; k < 60 && o_boot_done !== 1'b1; k++) @(posedge i_clk);
      check(o_vector, {rd(0), rd(1)});
      seen_full = 0;
      repeat (60) begin
        slow <= 1'($urandom);
        push($urandom_range(0, 2) == 0, $urandom_range(0, 4) == 0, $urandom & 32'h20080f);
      end
      push(0, 0, 1);
      i_req_valid <= 0;
      for (k = 0; k < 3000 && q.size() > 0; k++) @(posedge i_clk);
      check(q.size(), 0);
      check(seen_full, 1);
      i_bus_release <= 1;
      repeat (6) @(posedge i_clk);
      check(o_ctrl_oe, 0);
      i_bus_release <= 0;
      repeat (6) @(posedge i_clk);
    end
    end_sim();
  end
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule : emb_bus_tb
